// ### verilog/abs_consts.vh
// Constants for the analog boundary-scan cell chain
`ifndef ABS_CONSTS_VH
`define ABS_CONSTS_VH

// ************************************************************
// Chain layout, bit 0 sits next to the test data output
// ************************************************************
`define ABS_CHAIN_LEN        29
`define ABS_POS_CMP_RESULT   0
`define ABS_POS_CONV_RESULT  1
`define ABS_POS_OSC_OBS      2
`define ABS_POS_CMP_OFF      3
`define ABS_POS_CMP_MUXSEL   4
`define ABS_POS_CMP_BGEN     5
`define ABS_POS_GAIN_CLK     6
`define ABS_POS_GAIN_PATH    7
`define ABS_POS_CONV_BG      8
`define ABS_POS_CONV_PWR     9
`define ABS_POS_AMP_PWR      10
`define ABS_POS_DAC_LO       11
`define ABS_POS_BYPASS       21
`define ABS_POS_GAIN10       22
`define ABS_POS_GAIN20       23
`define ABS_POS_NEG_GND      24
`define ABS_POS_HOLD         25
`define ABS_POS_OSC_EN_LO    26
`define ABS_NUM_OSC          3
`define ABS_DAC_W            10

// ************************************************************
// Safe update-latch values after reset
// ************************************************************
// Comparator off, DAC mid-scale, bypass and hold set, no clock enabled
`define ABS_RST_UPDATE       29'h02300008

`endif

// ### verilog/abs_scan_cell.v
// One general boundary-scan cell: capture/shift stage and update latch
`timescale 1ns/10ps
module abs_scan_cell (
  clk,
  srst,
  shiftEn,
  captureEn,
  updateEn,
  resetVal,
  sysIn,
  scanIn,
  scanOut,
  cellOut
);
  input  wire clk;
  input  wire srst;
  input  wire shiftEn;
  input  wire captureEn;
  input  wire updateEn;
  input  wire resetVal;
  input  wire sysIn;
  input  wire scanIn;
  output reg  scanOut;
  output reg  cellOut;

  // Reset value is a tied constant per instance
  always @(posedge clk) begin
    if (srst) begin
      scanOut <= 1'b0;
      cellOut <= resetVal;
    end else begin
      if (captureEn)
        scanOut <= sysIn;
      else if (shiftEn)
        scanOut <= scanIn;
      if (updateEn)
        cellOut <= scanOut;
    end
  end
endmodule // abs_scan_cell

// ### verilog/abs_analog_scan.v
// Boundary-scan chain across the comparator, converter and clock enables
`timescale 1ns/10ps
`include "abs_consts.vh"

// Operation
// - Each clock-option enable has its own cell
// - No cell for internal load-cap setting
// - Every comparator signal has a scan cell
// - Every converter signal attached to a cell
// - Gain-stage clock driven from its cell
// - gain_path_enable links gain stages to comparator
// - converter_bandgap_select puts bandgap on negative input
// - converter_power_on powers the converter
// - amplifier_power_on powers the gain stages
// - Ten-bit DAC word from ten cells
// - gain_bypass_select bypasses gain for channels 0-3
// - negative_input_ground grounds comparator negative input
// - External test: capture, shift, update
module abs_analog_scan (
  clk,
  srst,
  tckRise,
  externalTestInstruction,
  captureDr,
  shiftDr,
  updateDr,
  tdi,
  tdo,
  sysComparatorOff,
  sysComparatorMuxSelect,
  sysComparatorBandgapEnable,
  sysGainClock,
  sysGainPathEnable,
  sysConverterBandgapSelect,
  sysConverterPowerOn,
  sysAmplifierPowerOn,
  sysDacWord,
  sysGainBypassSelect,
  sysGainTenEnable,
  sysGainTwentyEnable,
  sysNegativeInputGround,
  sysHold,
  sysOscEnable,
  comparatorResult,
  converterResult,
  oscObserve,
  comparatorOff,
  comparatorMuxSelect,
  comparatorBandgapEnable,
  gainClock,
  gainPathEnable,
  converterBandgapSelect,
  converterPowerOn,
  amplifierPowerOn,
  dacWord,
  gainBypassSelect,
  gainTenEnable,
  gainTwentyEnable,
  negativeInputGround,
  hold,
  oscEnable,
  cmpResultToLogic,
  convResultToLogic
);
  input  wire       clk;
  input  wire       srst;
  input  wire       tckRise;
  input  wire       externalTestInstruction;
  input  wire       captureDr;
  input  wire       shiftDr;
  input  wire       updateDr;
  input  wire       tdi;
  output reg        tdo;
  input  wire       sysComparatorOff;
  input  wire       sysComparatorMuxSelect;
  input  wire       sysComparatorBandgapEnable;
  input  wire       sysGainClock;
  input  wire       sysGainPathEnable;
  input  wire       sysConverterBandgapSelect;
  input  wire       sysConverterPowerOn;
  input  wire       sysAmplifierPowerOn;
  input  wire [9:0] sysDacWord;
  input  wire       sysGainBypassSelect;
  input  wire       sysGainTenEnable;
  input  wire       sysGainTwentyEnable;
  input  wire       sysNegativeInputGround;
  input  wire       sysHold;
  input  wire [2:0] sysOscEnable;
  input  wire       comparatorResult;
  input  wire       converterResult;
  input  wire       oscObserve;
  output reg        comparatorOff;
  output reg        comparatorMuxSelect;
  output reg        comparatorBandgapEnable;
  output reg        gainClock;
  output reg        gainPathEnable;
  output reg        converterBandgapSelect;
  output reg        converterPowerOn;
  output reg        amplifierPowerOn;
  output reg  [9:0] dacWord;
  output reg        gainBypassSelect;
  output reg        gainTenEnable;
  output reg        gainTwentyEnable;
  output reg        negativeInputGround;
  output reg        hold;
  output reg  [2:0] oscEnable;
  output reg        cmpResultToLogic;
  output reg        convResultToLogic;

  // ************************************************************
  // Chain signals
  // ************************************************************
  wire [`ABS_CHAIN_LEN-1:0] sysVec;
  wire [`ABS_CHAIN_LEN-1:0] rstVec;
  wire [`ABS_CHAIN_LEN-1:0] stage;
  wire [`ABS_CHAIN_LEN-1:0] latch;
  wire [`ABS_CHAIN_LEN:0]   chainIn;
  wire                      shiftEn;
  wire                      captureEn;
  wire                      updateEn;

  // Strobes act only on test-clock rising edges
  assign shiftEn   = externalTestInstruction & shiftDr & tckRise;
  assign captureEn = externalTestInstruction & captureDr & tckRise;
  assign updateEn  = externalTestInstruction & updateDr & tckRise;

  // Observed levels feed the capture stage directly
  assign sysVec = {sysOscEnable, sysHold, sysNegativeInputGround,
                   sysGainTwentyEnable, sysGainTenEnable,
                   sysGainBypassSelect, sysDacWord, sysAmplifierPowerOn,
                   sysConverterPowerOn, sysConverterBandgapSelect,
                   sysGainPathEnable, sysGainClock,
                   sysComparatorBandgapEnable, sysComparatorMuxSelect,
                   sysComparatorOff, oscObserve, converterResult,
                   comparatorResult};
  assign rstVec  = `ABS_RST_UPDATE;
  assign chainIn[`ABS_CHAIN_LEN] = tdi;

  // ************************************************************
  // Cell chain, tdi enters at the top bit
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < `ABS_CHAIN_LEN; i = i + 1) begin : gCell
      abs_scan_cell uCell (
        .clk       (clk),
        .srst      (srst),
        .shiftEn   (shiftEn),
        .captureEn (captureEn),
        .updateEn  (updateEn),
        .resetVal  (rstVec[i]),
        .sysIn     (sysVec[i]),
        .scanIn    (chainIn[i+1]),
        .scanOut   (stage[i]),
        .cellOut   (latch[i])
      );
      assign chainIn[i] = stage[i];
    end
  endgenerate

  // ************************************************************
  // Output mux: chain drives analog side only in external test
  // ************************************************************
  always @(posedge clk) begin
    if (srst) begin
      tdo                     <= 1'b0;
      comparatorOff           <= 1'b0;
      comparatorMuxSelect     <= 1'b0;
      comparatorBandgapEnable <= 1'b0;
      gainClock               <= 1'b0;
      gainPathEnable          <= 1'b0;
      converterBandgapSelect  <= 1'b0;
      converterPowerOn        <= 1'b0;
      amplifierPowerOn        <= 1'b0;
      dacWord                 <= 10'h000;
      gainBypassSelect        <= 1'b0;
      gainTenEnable           <= 1'b0;
      gainTwentyEnable        <= 1'b0;
      negativeInputGround     <= 1'b0;
      hold                    <= 1'b0;
      oscEnable               <= 3'h0;
      cmpResultToLogic        <= 1'b0;
      convResultToLogic       <= 1'b0;
    end else begin
      tdo <= stage[0];
      cmpResultToLogic  <= externalTestInstruction ?
                           latch[`ABS_POS_CMP_RESULT] :
                           comparatorResult;
      convResultToLogic <= externalTestInstruction ?
                           latch[`ABS_POS_CONV_RESULT] :
                           converterResult;
      if (externalTestInstruction) begin
        comparatorOff           <= latch[`ABS_POS_CMP_OFF];
        comparatorMuxSelect     <= latch[`ABS_POS_CMP_MUXSEL];
        comparatorBandgapEnable <= latch[`ABS_POS_CMP_BGEN];
        gainClock               <= latch[`ABS_POS_GAIN_CLK];
        gainPathEnable          <= latch[`ABS_POS_GAIN_PATH];
        converterBandgapSelect  <= latch[`ABS_POS_CONV_BG];
        converterPowerOn        <= latch[`ABS_POS_CONV_PWR];
        amplifierPowerOn        <= latch[`ABS_POS_AMP_PWR];
        dacWord                 <= latch[`ABS_POS_DAC_LO+9:
                                         `ABS_POS_DAC_LO];
        gainBypassSelect        <= latch[`ABS_POS_BYPASS];
        gainTenEnable           <= latch[`ABS_POS_GAIN10];
        gainTwentyEnable        <= latch[`ABS_POS_GAIN20];
        negativeInputGround     <= latch[`ABS_POS_NEG_GND];
        hold                    <= latch[`ABS_POS_HOLD];
        // Separate cells stop sleep logic cutting oscillator pins
        oscEnable <= latch[`ABS_POS_OSC_EN_LO+2:
                           `ABS_POS_OSC_EN_LO];
      end else begin
        comparatorOff           <= sysComparatorOff;
        comparatorMuxSelect     <= sysComparatorMuxSelect;
        comparatorBandgapEnable <= sysComparatorBandgapEnable;
        gainClock               <= sysGainClock;
        gainPathEnable          <= sysGainPathEnable;
        converterBandgapSelect  <= sysConverterBandgapSelect;
        converterPowerOn        <= sysConverterPowerOn;
        amplifierPowerOn        <= sysAmplifierPowerOn;
        dacWord                 <= sysDacWord;
        gainBypassSelect        <= sysGainBypassSelect;
        gainTenEnable           <= sysGainTenEnable;
        gainTwentyEnable        <= sysGainTwentyEnable;
        negativeInputGround     <= sysNegativeInputGround;
        hold                    <= sysHold;
        oscEnable               <= sysOscEnable;
      end
    end
  end
  // Load-cap setting stays with configuration, never scanned
endmodule // abs_analog_scan

// ### verif/abs_analog_scan_checker.sv
// Assertions on the analog boundary-scan chain ports
`timescale 1ns/10ps
module abs_analog_scan_checker (
  input wire       clk,
  input wire       srst,
  input wire       tckRise,
  input wire       externalTestInstruction,
  input wire       captureDr,
  input wire       shiftDr,
  input wire       updateDr,
  input wire       tdo,
  input wire       sysComparatorOff,
  input wire       sysHold,
  input wire [9:0] sysDacWord,
  input wire       comparatorResult,
  input wire       comparatorOff,
  input wire       hold,
  input wire [9:0] dacWord,
  input wire       gainBypassSelect,
  input wire       cmpResultToLogic
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire ext  = externalTestInstruction;
  wire move = tckRise & ext & (captureDr | shiftDr);
  wire upd  = tckRise & ext & updateDr;
  sequence s_capture;
    tckRise && ext && captureDr;
  endsequence
  // Stage untouched for one edge, reset quiet across two
  sequence s_quiet;
    !srst && !move ##1 !srst;
  endsequence
  property p_capture;
    s_capture |-> ##2 tdo == $past(comparatorResult, 2);
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost");
  property p_quiet;
    s_quiet |=> $stable(tdo);
  endproperty
  a_quiet: assert property (p_quiet) else $error("tdo moved");
  property p_follow_off;
    !ext |=> comparatorOff == $past(sysComparatorOff);
  endproperty
  a_follow_off: assert property (p_follow_off) else $error("off");
  property p_follow_dac;
    !ext |=> dacWord == $past(sysDacWord);
  endproperty
  a_follow_dac: assert property (p_follow_dac) else $error("dac");
  property p_follow_hold;
    !ext |=> hold == $past(sysHold);
  endproperty
  a_follow_hold: assert property (p_follow_hold) else $error("hold");
  property p_live;
    !ext |=> cmpResultToLogic == $past(comparatorResult);
  endproperty
  a_live: assert property (p_live) else $error("result path");
  property p_safe;
    $past(srst) && !srst && ext |=> comparatorOff && hold &&
      gainBypassSelect && dacWord == 10'h200;
  endproperty
  a_safe: assert property (p_safe) else $error("safe values");
  // Latch moves only two edges after an update strobe
  property p_stable;
    (ext && !upd)[*3] |-> $stable(dacWord) && $stable(hold);
  endproperty
  a_stable: assert property (p_stable) else $error("latch moved");
endmodule // abs_analog_scan_checker

bind abs_analog_scan abs_analog_scan_checker i_abs_analog_scan_checker (
  .clk, .srst, .tckRise, .externalTestInstruction, .captureDr, .shiftDr,
  .updateDr, .tdo, .sysComparatorOff, .sysHold, .sysDacWord,
  .comparatorResult, .comparatorOff, .hold, .dacWord, .gainBypassSelect,
  .cmpResultToLogic
);

// ### verif/abs_jtag_tester.sv
// Tester model that strobes the scan chain as the TAP would
`timescale 1ns/10ps
module abs_jtag_tester (
  input  wire clk,
  input  wire tdo,
  output reg  tckRise   = 1'b0,
  output reg  captureDr = 1'b0,
  output reg  shiftDr   = 1'b0,
  output reg  updateDr  = 1'b0,
  output reg  tdi       = 1'b0
);
  // One test-clock edge in one state, then quiet until tdo settles
  task strobe(input logic c, input logic s, input logic u, input logic d);
    begin
      @(negedge clk);
      {captureDr, shiftDr, updateDr, tdi, tckRise} <= {c, s, u, d, 1'b1};
      @(negedge clk);
      tckRise <= 1'b0;
      tdi     <= ~d; // Stale data never repeats the last bit
      @(negedge clk);
    end
  endtask
  task shift_chain(input logic [28:0] din, output logic [28:0] dout);
    integer i;
    begin
      for (i = 0; i < 29; i = i + 1) begin
        dout[i] = tdo;
        strobe(1'b0, 1'b1, 1'b0, din[i]);
      end
    end
  endtask
endmodule // abs_jtag_tester

// ### verif/abs_analog_scan_bench.sv
// Self-checking bench for the analog boundary-scan chain
`timescale 1ns/10ps
module abs_analog_scan_bench;
  reg         clk = 1'b0;
  reg         srst = 1'b1;
  reg         ext = 1'b1;
  reg  [28:0] sv = 29'h0;
  wire [28:0] ov;
  wire        tck, cap, sh, upd, tdi, tdo;
  integer     errors = 0;
  integer     samples_checked = 0;
  integer     cycles = 0;
  assign ov[2] = 1'b0;
  always #5 clk = ~clk;
  abs_jtag_tester i_abs_jtag_tester (.clk(clk), .tdo(tdo), .tckRise(tck),
    .captureDr(cap), .shiftDr(sh), .updateDr(upd), .tdi(tdi));
  abs_analog_scan i_abs_analog_scan (
    .clk(clk), .srst(srst), .tckRise(tck), .externalTestInstruction(ext),
    .captureDr(cap), .shiftDr(sh), .updateDr(upd), .tdi(tdi), .tdo(tdo),
    .sysComparatorOff(sv[3]), .sysComparatorMuxSelect(sv[4]),
    .sysComparatorBandgapEnable(sv[5]), .sysGainClock(sv[6]),
    .sysGainPathEnable(sv[7]), .sysConverterBandgapSelect(sv[8]),
    .sysConverterPowerOn(sv[9]), .sysAmplifierPowerOn(sv[10]),
    .sysDacWord(sv[20:11]), .sysGainBypassSelect(sv[21]),
    .sysGainTenEnable(sv[22]), .sysGainTwentyEnable(sv[23]),
    .sysNegativeInputGround(sv[24]), .sysHold(sv[25]),
    .sysOscEnable(sv[28:26]), .comparatorResult(sv[0]),
    .converterResult(sv[1]), .oscObserve(sv[2]),
    .comparatorOff(ov[3]), .comparatorMuxSelect(ov[4]),
    .comparatorBandgapEnable(ov[5]), .gainClock(ov[6]),
    .gainPathEnable(ov[7]), .converterBandgapSelect(ov[8]),
    .converterPowerOn(ov[9]), .amplifierPowerOn(ov[10]),
    .dacWord(ov[20:11]), .gainBypassSelect(ov[21]),
    .gainTenEnable(ov[22]), .gainTwentyEnable(ov[23]),
    .negativeInputGround(ov[24]), .hold(ov[25]), .oscEnable(ov[28:26]),
    .cmpResultToLogic(ov[0]), .convResultToLogic(ov[1])
  );
  task check(input [8*8-1:0] name, input [28:0] exp, input [28:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("Error %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task end_sim;
    begin
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors = errors + 1;
      end_sim;
    end
  end
  task t_safe;
    begin
      repeat (3) @(negedge clk);
      check("safe", 29'h02300008, ov);
    end
  endtask
  // Oscillator observe is a steady level, one clock source at a time
  task t_external_test_instruction(input [28:0] p, input [28:0] q);
    reg [28:0] got;
    begin
      @(negedge clk);
      sv = p;
      i_abs_jtag_tester.strobe(1'b1, 1'b0, 1'b0, 1'b0);
      i_abs_jtag_tester.shift_chain(q, got);
      check("capture", p, got);
      i_abs_jtag_tester.strobe(1'b0, 1'b0, 1'b1, 1'b0);
      repeat (2) @(negedge clk);
      check("update", q & 29'h1ffffffb, ov);
    end
  endtask
  // New pattern waits in the stage, so a leaked update would show
  task t_refused;
    reg [28:0] junk;
    begin
      i_abs_jtag_tester.shift_chain(29'h05555555, junk);
      check("shifted", 29'h0aaaaaaa, junk);
      @(negedge clk);
      ext = 1'b0;
      sv = 29'h0ffffffb;
      i_abs_jtag_tester.strobe(1'b0, 1'b0, 1'b1, 1'b0);
      check("follow", sv, ov);
      ext = 1'b1;
      repeat (2) @(negedge clk);
      check("refused", 29'h0aaaaaaa, ov);
    end
  endtask
  initial begin
    repeat (20) @(negedge clk);
    srst = 1'b0;
    t_safe;
    t_external_test_instruction(29'h0aaaaaaa, 29'h05555555);
    t_external_test_instruction(29'h05555555, 29'h0aaaaaaa);
    t_refused;
    end_sim;
  end
endmodule // abs_analog_scan_bench
